// >>> bench/motion_status_word_and_node_address_bench.sv
`timescale 1ns/10ps
module motion_status_word_and_node_address_bench;
  logic i_sys_clk, i_resetn, req, valid, mv, inpos, vel, traj, follow, men, edis, rng, loc, amode, fsamp;
  logic conn, perr, pclr, alvl, estop, ev1, ev2, plim, nlim, sav, fav, sacc, facc, sboot;
  logic [15:0] word, got, p;
  logic [9:0] sw, cfg, simg;
  logic [5:0] saddr, faddr, node, spd;
  int fails, cmp_count, cycles, i;
  msw_host u_msw_host (.i_sys_clk(i_sys_clk), .o_status_req(req), .i_status_valid(valid), .i_status_word(word));
  msw_status u_msw_status (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_status_req(req),
    .o_status_word(word), .o_status_valid(valid), .i_move_active(mv), .i_in_position(inpos),
    .i_velocity_mode(vel), .i_traj_pct_done(traj), .i_following_err(follow), .i_motor_enabled(men),
    .i_error_disable(edis), .i_range_limit_hit(rng), .i_local_mode(loc), .i_analog_input_mode(amode),
    .i_filter_sample(fsamp), .i_fb_conn_active(conn), .i_fb_pkt_error(perr), .i_fb_err_clear(pclr),
    .i_config_sw(sw), .i_analog_level(alvl), .i_estop(estop), .i_event1(ev1), .i_event2(ev2),
    .i_pos_limit(plim), .i_neg_limit(nlim), .i_stored_config_boot(sboot), .i_stored_config(simg),
    .i_serial_addr_valid(sav), .i_serial_addr(saddr), .i_fb_addr_valid(fav), .i_fb_addr(faddr),
    .o_serial_accept(sacc), .o_fb_accept(facc), .o_config(cfg), .o_network_node_id(node), .o_speed_range(spd));
  // clock, 40 ns period
  initial
  begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  // hang guard, well above the expected run length
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic check_word(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED at %0t: status %h expected %h", $time, g, e);
    end
  endtask : check_word
  task automatic check_cfg(input logic [9:0] g, input logic [9:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, g, e);
    end
  endtask : check_cfg
  // every status bit but packet error bit 6 from one pattern; analog mode 1 so bit 3 follows the pin
  task automatic apply(input logic [15:0] v);
    {nlim, ev2, plim, ev1, estop, loc, rng, follow, conn, traj, alvl, vel, inpos, mv} =
      {v[15:9], v[7], v[5:0]};
    men = ~v[8];
    amode = 1'b1;
  endtask : apply
  // pins pass two sync flops, so let them settle before the request
  task automatic expect_status(input logic [15:0] e);
    repeat (3) @(negedge i_sys_clk);
    u_msw_host.read_status(got);
    check_word(got, e);
  endtask : expect_status
  task automatic fb_flag(input logic e, input logic c, input logic [15:0] x);
    @(negedge i_sys_clk);
    perr = e;
    pclr = c;
    @(negedge i_sys_clk);
    perr = 1'b0;
    pclr = 1'b0;
    expect_status(x);
  endtask : fb_flag
  task automatic try_addr(input logic ser, input logic [5:0] a, input logic e);
    @(negedge i_sys_clk);
    sav = ser;
    fav = ~ser;
    saddr = a;
    faddr = a;
    @(negedge i_sys_clk);
    sav = 1'b0;
    fav = 1'b0;
    check_cfg({9'h000, ser ? sacc : facc}, {9'h000, e});
  endtask : try_addr
  task automatic report_and_stop();
    $display("counts: %0d checks, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    {i_resetn, edis, fsamp, perr, pclr, sav, fav, saddr, faddr, sboot, simg} = '0;
    fails = 0;
    cmp_count = 0;
    cycles = 0;
    apply(16'h0000);
    sw = 10'h2b3;
    repeat (10) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    repeat (6) @(negedge i_sys_clk);
    check_cfg(cfg, 10'h2b3);
    check_cfg({4'h0, node}, 10'h02b);
    // one source at a time; the sticky packet flag is left alone here
    for (i = 0; i < 16; i++)
    begin
      p = 16'h0001 << i;
      apply(p);
      expect_status(p & 16'hffbf);
    end
    $display("test walking_bits done");
    apply(16'h0000);
    amode = 1'b0;
    edis = 1'b1;
    expect_status(16'h0108);
    edis = 1'b0;
    $display("test analog_mode_and_error_disable done");
    fb_flag(1'b1, 1'b0, 16'h0048);
    fb_flag(1'b0, 1'b1, 16'h0008);
    fb_flag(1'b1, 1'b1, 16'h0048);
    $display("test packet_error done");
    try_addr(1'b1, 6'h2b, 1'b1);
    try_addr(1'b1, 6'h00, 1'b1);
    try_addr(1'b1, 6'h2a, 1'b0);
    try_addr(1'b0, 6'h2b, 1'b1);
    try_addr(1'b0, 6'h00, 1'b0);
    $display("test address_match done");
    loc = 1'b1;
    sw = 10'h0c0;
    repeat (6) @(negedge i_sys_clk);
    check_cfg(cfg, 10'h0c3);
    check_cfg({4'h0, node}, 10'h00c);
    vel = 1'b1;
    check_cfg({4'h0, spd}, 10'h000);
    fsamp = 1'b1;
    @(negedge i_sys_clk);
    fsamp = 1'b0;
    check_cfg({4'h0, spd}, 10'h00c);
    loc = 1'b0;
    sw = 10'h3ff;
    repeat (6) @(negedge i_sys_clk);
    check_cfg(cfg, 10'h0c3);
    $display("test switch_resample done");
    // second power-up from the stored image; its address field is 0, so fieldbus node 0 is exercised
    sboot = 1'b1;
    simg = 10'h00d;
    i_resetn = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    repeat (6) @(negedge i_sys_clk);
    check_cfg(cfg, 10'h00d);
    check_cfg({4'h0, node}, 10'h000);
    expect_status(16'h000c);
    try_addr(1'b0, 6'h00, 1'b1);
    try_addr(1'b0, 6'h2b, 1'b0);
    try_addr(1'b1, 6'h00, 1'b1);
    $display("test stored_boot done");
    report_and_stop();
  end
endmodule : motion_status_word_and_node_address_bench

// >>> bench/msw_host.sv
`timescale 1ns/10ps
module msw_host
(
  // clock
  input wire logic i_sys_clk,
  // status request handshake
  output logic o_status_req,
  input wire logic i_status_valid,
  input wire logic [msw_pkg::STATUS_W-1:0] i_status_word
);
  initial o_status_req = 1'b0;
  // one single-cycle request per call; a lost answer returns unknowns so no compare can pass
  task automatic read_status(output logic [msw_pkg::STATUS_W-1:0] word);
    int k;
    word = 'x;
    @(negedge i_sys_clk);
    o_status_req = 1'b1;
    @(negedge i_sys_clk);
    o_status_req = 1'b0;
    for (k = 0; k < 4 && i_status_valid !== 1'b1; k++)
      @(negedge i_sys_clk);
    if (i_status_valid === 1'b1)
      word = i_status_word;
  endtask : read_status
endmodule : msw_host

// >>> rtl/msw_pkg.sv
package msw_pkg;
  // widths
  localparam int STATUS_W = 16;
  localparam int SW_COUNT = 10;
  localparam int ADDR_W = 6;
  localparam int SYNC_W = 16;
  // switch field positions (index 0 is switch 1)
  localparam int SW_ADDR_LSB = 4;
  localparam int SW_LOCAL_LSB = 2;
  // status bit positions
  localparam int ST_MOVE = 0;
  localparam int ST_INPOS = 1;
  localparam int ST_VEL = 2;
  localparam int ST_ANALOG = 3;
  localparam int ST_TRAJ = 4;
  localparam int ST_CONN = 5;
  localparam int ST_PKTERR = 6;
  localparam int ST_FOLLOW = 7;
  localparam int ST_DISABLED = 8;
  localparam int ST_RANGE = 9;
  localparam int ST_LOCAL = 10;
  localparam int ST_ESTOP = 11;
  localparam int ST_EVENT1 = 12;
  localparam int ST_POSLIM = 13;
  localparam int ST_EVENT2 = 14;
  localparam int ST_NEGLIM = 15;
  // synchronised pin vector positions (switches occupy 0..9)
  localparam int PIN_ANALOG = 10;
  localparam int PIN_ESTOP = 11;
  localparam int PIN_EVENT1 = 12;
  localparam int PIN_EVENT2 = 13;
  localparam int PIN_POSLIM = 14;
  localparam int PIN_NEGLIM = 15;
  // reset values and timing
  localparam logic [STATUS_W-1:0] STATUS_RST = 16'h0000;
  localparam logic [SW_COUNT-1:0] SW_RST = 10'h3ff;
  localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;
  localparam logic [ADDR_W-1:0] BCAST_ADDR = 6'h00;
  localparam logic [1:0] LOAD_WAIT = 2'h2;
endpackage : msw_pkg

// >>> rtl/msw_status.sv
`timescale 1ns/10ps
module msw_status
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // host status request
  input wire logic i_status_req,
  output logic [msw_pkg::STATUS_W-1:0] o_status_word,
  output logic o_status_valid,
  // motion state from trajectory and servo logic
  input wire logic i_move_active,
  input wire logic i_in_position,
  input wire logic i_velocity_mode,
  input wire logic i_traj_pct_done,
  input wire logic i_following_err,
  input wire logic i_motor_enabled,
  input wire logic i_error_disable,
  input wire logic i_range_limit_hit,
  input wire logic i_local_mode,
  input wire logic i_analog_input_mode,
  input wire logic i_filter_sample,
  // fieldbus state
  input wire logic i_fb_conn_active,
  input wire logic i_fb_pkt_error,
  input wire logic i_fb_err_clear,
  // pins from outside the clock domain
  input wire logic [msw_pkg::SW_COUNT-1:0] i_config_sw,
  input wire logic i_analog_level,
  input wire logic i_estop,
  input wire logic i_event1,
  input wire logic i_event2,
  input wire logic i_pos_limit,
  input wire logic i_neg_limit,
  // stored configuration boot
  input wire logic i_stored_config_boot,
  input wire logic [msw_pkg::SW_COUNT-1:0] i_stored_config,
  // address matching
  input wire logic i_serial_addr_valid,
  input wire logic [msw_pkg::ADDR_W-1:0] i_serial_addr,
  input wire logic i_fb_addr_valid,
  input wire logic [msw_pkg::ADDR_W-1:0] i_fb_addr,
  output logic o_serial_accept,
  output logic o_fb_accept,
  // decoded configuration
  output logic [msw_pkg::SW_COUNT-1:0] o_config,
  output logic [msw_pkg::ADDR_W-1:0] o_network_node_id,
  output logic [msw_pkg::ADDR_W-1:0] o_speed_range
);

  // six-bit field of switches 5..10; pins already read on as 0
  function automatic logic [msw_pkg::ADDR_W-1:0] msw_sw_field(input logic [msw_pkg::SW_COUNT-1:0] sw);
    msw_sw_field = sw[msw_pkg::SW_ADDR_LSB +: msw_pkg::ADDR_W];
  endfunction : msw_sw_field

  logic [msw_pkg::SYNC_W-1:0] sync_a;
  logic [msw_pkg::SYNC_W-1:0] sync_b;
  logic [1:0] load_cnt;
  logic cfg_loaded;
  logic pkt_err_flag;
  logic [msw_pkg::SW_COUNT-1:0] cfg;
  wire [msw_pkg::SYNC_W-1:0] pins_raw;
  wire [msw_pkg::SW_COUNT-1:0] sw_now;
  wire [msw_pkg::SW_COUNT-1:0] cfg_src;
  wire [msw_pkg::SW_COUNT-1:0] next_cfg;
  wire [msw_pkg::ADDR_W-1:0] node_addr;
  wire [msw_pkg::STATUS_W-1:0] next_status;
  wire load_now;
  wire serial_hit;
  wire fb_hit;

  // all pins share one two-stage synchroniser
  assign pins_raw = {i_neg_limit, i_pos_limit, i_event2, i_event1, i_estop, i_analog_level, i_config_sw};

  // only the second stage is read by logic
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sync_a <= {msw_pkg::SYNC_W{1'b0}};
      sync_b <= {msw_pkg::SYNC_W{1'b0}};
    end
    else
    begin
      sync_a <= pins_raw;
      sync_b <= sync_a;
    end
  end

  // switch on pulls the pin low, so the raw level is the decoded bit
  assign sw_now = sync_b[msw_pkg::SW_COUNT-1:0];

  // power-up latch waits until the synchroniser holds real pin values
  assign load_now = !cfg_loaded && (load_cnt == msw_pkg::LOAD_WAIT);
  assign cfg_src = i_stored_config_boot ? i_stored_config : sw_now;

  // local mode resamples switches 3..10 live; 1 and 2 stay latched
  assign next_cfg = load_now ? cfg_src
                  : (cfg_loaded && i_local_mode) ? {sw_now[msw_pkg::SW_COUNT-1:msw_pkg::SW_LOCAL_LSB],
                                                    cfg[msw_pkg::SW_LOCAL_LSB-1:0]}
                  : cfg;

  // configuration latch; caught by the third clock after release, never by reset
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      load_cnt <= 2'h0;
      cfg_loaded <= 1'b0;
      cfg <= msw_pkg::SW_RST;
    end
    else
    begin
      if (!cfg_loaded && load_cnt != msw_pkg::LOAD_WAIT)
        load_cnt <= load_cnt + 2'h1;
      if (load_now)
        cfg_loaded <= 1'b1;
      cfg <= next_cfg;
    end
  end

  // all switches on reads 0
  assign node_addr = msw_sw_field(cfg);

  // serial: own address or broadcast 0; fieldbus: exact match only
  assign serial_hit = (i_serial_addr == node_addr) || (i_serial_addr == msw_pkg::BCAST_ADDR);
  assign fb_hit = (i_fb_addr == node_addr);

  // sticky packet error; a new error beats a clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      pkt_err_flag <= 1'b0;
    else if (i_fb_pkt_error)
      pkt_err_flag <= 1'b1;
    else if (i_fb_err_clear)
      pkt_err_flag <= 1'b0;
  end

  // status word assembly; events only appear here, nothing else reacts
  assign next_status[msw_pkg::ST_MOVE] = i_move_active;
  assign next_status[msw_pkg::ST_INPOS] = i_in_position;
  assign next_status[msw_pkg::ST_VEL] = i_velocity_mode;
  assign next_status[msw_pkg::ST_ANALOG] = i_analog_input_mode ? sync_b[msw_pkg::PIN_ANALOG] : 1'b1;
  assign next_status[msw_pkg::ST_TRAJ] = i_traj_pct_done;
  assign next_status[msw_pkg::ST_CONN] = i_fb_conn_active;
  assign next_status[msw_pkg::ST_PKTERR] = pkt_err_flag;
  assign next_status[msw_pkg::ST_FOLLOW] = i_following_err;
  assign next_status[msw_pkg::ST_DISABLED] = !i_motor_enabled || i_error_disable;
  assign next_status[msw_pkg::ST_RANGE] = i_range_limit_hit;
  assign next_status[msw_pkg::ST_LOCAL] = i_local_mode;
  assign next_status[msw_pkg::ST_ESTOP] = sync_b[msw_pkg::PIN_ESTOP];
  assign next_status[msw_pkg::ST_EVENT1] = sync_b[msw_pkg::PIN_EVENT1];
  assign next_status[msw_pkg::ST_POSLIM] = sync_b[msw_pkg::PIN_POSLIM];
  assign next_status[msw_pkg::ST_EVENT2] = sync_b[msw_pkg::PIN_EVENT2];
  assign next_status[msw_pkg::ST_NEGLIM] = sync_b[msw_pkg::PIN_NEGLIM];

  // snapshot on request: all bits from one cycle, held until next request
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_status_word <= msw_pkg::STATUS_RST;
      o_status_valid <= 1'b0;
    end
    else
    begin
      o_status_valid <= i_status_req;
      if (i_status_req)
        o_status_word <= next_status;
    end
  end

  // address match strobes, one cycle after the address is offered
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_serial_accept <= 1'b0;
      o_fb_accept <= 1'b0;
    end
    else
    begin
      o_serial_accept <= i_serial_addr_valid && serial_hit;
      o_fb_accept <= i_fb_addr_valid && fb_hit;
    end
  end

  // decoded outputs; the speed range only moves at a filter sample
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_config <= msw_pkg::SW_RST;
      o_network_node_id <= msw_pkg::ADDR_RST;
      o_speed_range <= msw_pkg::ADDR_RST;
    end
    else
    begin
      o_config <= cfg;
      o_network_node_id <= node_addr;
      if (i_filter_sample && i_velocity_mode)
        o_speed_range <= node_addr;
    end
  end

  // checks
  snap_coherent_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> (o_status_word == $past(next_status)) && o_status_valid)
    else $error("status snapshot mismatch");
  snap_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !i_status_req |=> $stable(o_status_word))
    else $error("status word changed without request");
  analog_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_status_req && !i_analog_input_mode) |=> o_status_word[msw_pkg::ST_ANALOG])
    else $error("analog bit not forced to one");
  pkt_err_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_fb_pkt_error |=> pkt_err_flag)
    else $error("packet error lost");
  pkt_err_clr_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_fb_err_clear && !i_fb_pkt_error) |=> !pkt_err_flag)
    else $error("packet error not cleared");
  disabled_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_status_req && !i_motor_enabled) |=> o_status_word[msw_pkg::ST_DISABLED])
    else $error("disabled bit wrong");
  bcast_accept_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_serial_addr_valid && i_serial_addr == msw_pkg::BCAST_ADDR) |=> o_serial_accept)
    else $error("broadcast not accepted");
  fb_exact_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_fb_addr_valid && i_fb_addr != node_addr) |=> !o_fb_accept)
    else $error("fieldbus accepted foreign address");
  range_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !i_filter_sample |=> $stable(o_speed_range))
    else $error("speed range moved outside filter sample");
  latch_once_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (cfg_loaded && !i_local_mode) |=> $stable(cfg))
    else $error("configuration changed outside local mode");
  load_time_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(load_cnt == msw_pkg::LOAD_WAIT) |=> cfg_loaded)
    else $error("configuration not latched after wait");
  estop_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> o_status_word[msw_pkg::ST_ESTOP] == $past(sync_b[msw_pkg::PIN_ESTOP]))
    else $error("estop bit wrong");

  // each status bit but estop against the input behind it, as sampled in the request cycle
  move_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> o_status_word[msw_pkg::ST_MOVE] == $past(i_move_active))
    else $error("move bit wrong");
  inpos_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> o_status_word[msw_pkg::ST_INPOS] == $past(i_in_position))
    else $error("in-position bit wrong");
  vel_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> o_status_word[msw_pkg::ST_VEL] == $past(i_velocity_mode))
    else $error("velocity bit wrong");
  analog_follow_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_status_req && i_analog_input_mode) |=> o_status_word[msw_pkg::ST_ANALOG] ==
      $past(sync_b[msw_pkg::PIN_ANALOG]))
    else $error("analog bit does not follow the pin");
  traj_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> o_status_word[msw_pkg::ST_TRAJ] == $past(i_traj_pct_done))
    else $error("trajectory bit wrong");
  conn_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> o_status_word[msw_pkg::ST_CONN] == $past(i_fb_conn_active))
    else $error("connection bit wrong");
  pkt_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> o_status_word[msw_pkg::ST_PKTERR] == $past(pkt_err_flag))
    else $error("packet error bit wrong");
  follow_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> o_status_word[msw_pkg::ST_FOLLOW] == $past(i_following_err))
    else $error("following error bit wrong");
  enabled_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_status_req && i_motor_enabled && !i_error_disable) |=> !o_status_word[msw_pkg::ST_DISABLED])
    else $error("disabled bit set while enabled");
  errdis_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_status_req && i_error_disable) |=> o_status_word[msw_pkg::ST_DISABLED])
    else $error("error disable not reported");
  range_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> o_status_word[msw_pkg::ST_RANGE] == $past(i_range_limit_hit))
    else $error("range limit bit wrong");
  local_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> o_status_word[msw_pkg::ST_LOCAL] == $past(i_local_mode))
    else $error("local mode bit wrong");
  event1_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> o_status_word[msw_pkg::ST_EVENT1] == $past(sync_b[msw_pkg::PIN_EVENT1]))
    else $error("event one bit wrong");
  event2_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> o_status_word[msw_pkg::ST_EVENT2] == $past(sync_b[msw_pkg::PIN_EVENT2]))
    else $error("event two bit wrong");
  poslim_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> o_status_word[msw_pkg::ST_POSLIM] == $past(sync_b[msw_pkg::PIN_POSLIM]))
    else $error("positive limit bit wrong");
  neglim_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_status_req |=> o_status_word[msw_pkg::ST_NEGLIM] == $past(sync_b[msw_pkg::PIN_NEGLIM]))
    else $error("negative limit bit wrong");

  // handshake, sticky flag and address strobes; strobes must never linger
  valid_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !i_status_req |=> !o_status_valid)
    else $error("status valid without request");
  pkt_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (!i_fb_pkt_error && !i_fb_err_clear) |=> $stable(pkt_err_flag))
    else $error("packet error flag moved on its own");
  serial_own_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_serial_addr_valid && i_serial_addr == node_addr) |=> o_serial_accept)
    else $error("own serial address refused");
  serial_foreign_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_serial_addr_valid && i_serial_addr != node_addr && i_serial_addr != msw_pkg::BCAST_ADDR)
      |=> !o_serial_accept)
    else $error("serial accepted foreign address");
  fb_own_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_fb_addr_valid && i_fb_addr == node_addr) |=> o_fb_accept)
    else $error("own fieldbus address refused");
  no_accept_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !i_serial_addr_valid |=> !o_serial_accept)
    else $error("serial accept without address");
  fb_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !i_fb_addr_valid |=> !o_fb_accept)
    else $error("fieldbus accept without address");

  // switch latch and decode; a second reset must reload from the right source
  node_addr_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    cfg_loaded |=> o_network_node_id == $past(cfg[msw_pkg::SW_ADDR_LSB +: msw_pkg::ADDR_W]))
    else $error("node address not from switches 5 to 10");
  cfg_out_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    cfg_loaded |=> o_config == $past(cfg))
    else $error("configuration output stale");
  range_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_filter_sample && i_velocity_mode) |=> o_speed_range == $past(node_addr))
    else $error("speed range not loaded at filter sample");
  range_pos_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !i_velocity_mode |=> $stable(o_speed_range))
    else $error("speed range moved in position control");
  local_follow_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (cfg_loaded && i_local_mode) |=> cfg[msw_pkg::SW_COUNT-1:msw_pkg::SW_LOCAL_LSB] ==
      $past(sync_b[msw_pkg::SW_COUNT-1:msw_pkg::SW_LOCAL_LSB]))
    else $error("local switches not followed");
  fixed_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    cfg_loaded |=> $stable(cfg[msw_pkg::SW_LOCAL_LSB-1:0]))
    else $error("switches 1 and 2 changed after power-up");
  stored_boot_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (load_now && i_stored_config_boot) |=> cfg == $past(i_stored_config))
    else $error("stored image not latched");
  pin_boot_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (load_now && !i_stored_config_boot) |=> cfg == $past(sync_b[msw_pkg::SW_COUNT-1:0]))
    else $error("switch pins not latched");

  // scenario covers
  read_c: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) i_status_req ##1 o_status_valid);
  err_clash_c: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) i_fb_pkt_error && i_fb_err_clear);
  range_c: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_filter_sample && i_velocity_mode) ##1 $changed(o_speed_range));
  local_c: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) cfg_loaded && i_local_mode && $changed(cfg));
  bcast_c: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_serial_addr_valid && i_serial_addr == msw_pkg::BCAST_ADDR) ##1 o_serial_accept);

endmodule : msw_status
